// >>> fpi_pkg.sv
package fpi_pkg;

  // System clock and the one millisecond pacing tick derived from it.
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned CLK_NS          = 1_000_000_000 / CLK_HZ;
  localparam int unsigned TICK_NS         = 1_000_000;
  localparam int unsigned TICK_CYC        = TICK_NS / CLK_NS;

  // Button timing in milliseconds.
  localparam int unsigned DEBOUNCE_MS     = 20;
  localparam int unsigned HOLD_MS         = 5000;

  // Corrupted image pattern timing in milliseconds.
  localparam int unsigned BLINK_ON_MS     = 300;
  localparam int unsigned BLINK_OFF_MS    = 300;
  localparam int unsigned BLINK_GAP_MS    = 1500;
  localparam int unsigned FAULT_BLINKS    = 3;

  // Traffic flicker: half period, and how long one frame keeps it going.
  localparam int unsigned FLICKER_HALF_MS = 50;
  localparam int unsigned TRAFFIC_HOLD_MS = 100;

  localparam int unsigned NUM_PORTS       = 2;

  // Negotiated speed as reported by the PHY.
  typedef enum logic [1:0] {
    SPEED_10   = 2'h0,
    SPEED_100  = 2'h1,
    SPEED_1000 = 2'h2
  } fpi_speed_t;

  // Addressing mode codes for the restored configuration.
  typedef enum logic [1:0] {
    ADDR_STATIC         = 2'h0,
    ADDR_DHCP_LINKLOCAL = 2'h1
  } fpi_addr_mode_t;

  localparam logic [7:0] DFLT_COMMENT_LEN = 8'h00;
  localparam logic       DFLT_HOST_SERIAL = 1'h1;
  localparam logic       DFLT_PW_NEEDED   = 1'h0;

endpackage : fpi_pkg

// >>> fpi_pace_if.sv
`timescale 1ns/1ps
// Shared pacing: a one-cycle millisecond tick and a slow flicker square wave.
interface fpi_pace_if;
  logic tick_ms;
  logic flicker;
  modport src (output tick_ms, output flicker);
  modport snk (input tick_ms, input flicker);
endinterface : fpi_pace_if

// >>> fpi_debounce.sv
`timescale 1ns/1ps
module fpi_debounce #(
  parameter int unsigned DEB_MS = fpi_pkg::DEBOUNCE_MS
) (
  input  wire logic   clk,
  input  wire logic   rst,
  fpi_pace_if.snk     pace,
  input  wire logic   raw,
  output logic        stable
);
  import fpi_pkg::*;

  localparam int W = $clog2(DEB_MS + 1);

  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic         next_stable;

  // The level only moves once it has disagreed through DEB_MS tick pulses.
  always_comb
  begin
    next_stable = stable;
    next_cnt    = cnt;
    if (raw == stable)
    begin
      next_cnt = '0;
    end
    else if (pace.tick_ms)
    begin
      if (cnt >= W'(DEB_MS - 1))
      begin
        next_stable = raw;   // [RULE_15]
        next_cnt    = '0;
      end
      else
      begin
        next_cnt = cnt + 1'b1;
      end
    end
  end

  // Released is the safe state after reset.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      stable <= 1'b0;
      cnt    <= '0;
    end
    else
    begin
      stable <= next_stable;
      cnt    <= next_cnt;
    end
  end

endmodule : fpi_debounce

// >>> fpi_fault_blink.sv
`timescale 1ns/1ps
module fpi_fault_blink #(
  parameter int unsigned ON_MS  = fpi_pkg::BLINK_ON_MS,
  parameter int unsigned OFF_MS = fpi_pkg::BLINK_OFF_MS,
  parameter int unsigned GAP_MS = fpi_pkg::BLINK_GAP_MS,
  parameter int unsigned BLINKS = fpi_pkg::FAULT_BLINKS
) (
  input  wire logic   clk,
  input  wire logic   rst,
  fpi_pace_if.snk     pace,
  input  wire logic   enable,
  output logic        lamp
);
  import fpi_pkg::*;

  localparam int W  = $clog2(GAP_MS + ON_MS + OFF_MS + 1);
  localparam int BW = $clog2(BLINKS + 1);

  typedef enum logic [1:0] {FB_IDLE, FB_ON, FB_OFF, FB_GAP} fpi_fb_state_t;

  fpi_fb_state_t state;
  fpi_fb_state_t next_state;
  logic [W-1:0]  cnt;
  logic [W-1:0]  next_cnt;
  logic [BW-1:0] blinks;
  logic [BW-1:0] next_blinks;
  logic          next_lamp;

  // Pattern: BLINKS flashes, then a long dark gap, repeated while enabled.
  always_comb
  begin
    next_state  = state;
    next_cnt    = cnt;
    next_blinks = blinks;
    case (state)
      FB_IDLE:
      begin
        next_cnt    = '0;
        next_blinks = '0;
        if (enable)
        begin
          next_state = FB_ON;
        end
      end
      FB_ON:
      begin
        if (pace.tick_ms)
        begin
          if (cnt >= W'(ON_MS - 1))
          begin
            next_state = FB_OFF;   // [RULE_16]
            next_cnt   = '0;
          end
          else
          begin
            next_cnt = cnt + 1'b1;
          end
        end
      end
      FB_OFF:
      begin
        if (pace.tick_ms)
        begin
          if (cnt >= W'(OFF_MS - 1))
          begin
            next_cnt = '0;
            if (blinks >= BW'(BLINKS - 1))
            begin
              next_state  = FB_GAP;   // [RULE_05]
              next_blinks = '0;
            end
            else
            begin
              next_state  = FB_ON;
              next_blinks = blinks + 1'b1;
            end
          end
          else
          begin
            next_cnt = cnt + 1'b1;
          end
        end
      end
      FB_GAP:
      begin
        if (pace.tick_ms)
        begin
          if (cnt >= W'(GAP_MS - 1))
          begin
            next_state = FB_ON;   // [RULE_16]
            next_cnt   = '0;
          end
          else
          begin
            next_cnt = cnt + 1'b1;
          end
        end
      end
      default:
      begin
        next_state = FB_IDLE;
      end
    endcase
    // Dropping the enable abandons the pattern at once.
    if (!enable)
    begin
      next_state = FB_IDLE;
    end
    next_lamp = (next_state == FB_ON);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state  <= FB_IDLE;
      cnt    <= '0;
      blinks <= '0;
      lamp   <= 1'b0;
    end
    else
    begin
      state  <= next_state;
      cnt    <= next_cnt;
      blinks <= next_blinks;
      lamp   <= next_lamp;
    end
  end

endmodule : fpi_fault_blink

// >>> fpi_front_panel.sv
`timescale 1ns/1ps
// How it works
// RULE_01: Power lamp follows the power-good input, dark without power.
// RULE_02: Activity lamp is lit while any acquisition task runs.
// RULE_03: Status lamp stays dark when no boot, update, restore or fault.
// RULE_04: Status lamp steady on during boot, update or factory restore.
// RULE_05: Corrupted firmware image flashes status lamp in groups of three.
// RULE_06: Speed lamp shows yellow at 1000 Mbps.
// RULE_07: Speed lamp shows green at 100 Mbps.
// RULE_08: Speed lamp dark without link or at 10 Mbps.
// RULE_09: Traffic lamp on with link, off without, blinking during frames.
// RULE_10: Two independent ports, each with its own speed and traffic lamps.
// RULE_11: Press shorter than five seconds reboots on release, keeping configuration.
// RULE_12: After five seconds held, status lamp lights while still pressed.
// RULE_13: Releasing a long press reboots into factory defaults.
// RULE_14: Defaults: serial-based host name, DHCP or link-local, empty comment, open admin.
// RULE_15: Reset button is debounced for milliseconds before hold timing starts.
// RULE_16: Fault blinks use fixed on and off times, long gap, repeating.
module fpi_front_panel #(
  parameter int unsigned TICK_CYC  = fpi_pkg::TICK_CYC,
  parameter int unsigned HOLD_MS   = fpi_pkg::HOLD_MS,
  parameter int unsigned DEB_MS    = fpi_pkg::DEBOUNCE_MS,
  parameter int unsigned NUM_PORTS = fpi_pkg::NUM_PORTS
) (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   power_good,
  input  wire logic                   task_running,
  input  wire logic                   fw_booting,
  input  wire logic                   fw_updating,
  input  wire logic                   fw_restoring,
  input  wire logic                   fw_image_corrupt,
  input  wire logic                   reset_button,
  input  wire logic [NUM_PORTS-1:0]   port_link_up,
  input  fpi_pkg::fpi_speed_t         port_speed [NUM_PORTS],
  input  wire logic [NUM_PORTS-1:0]   port_frame_seen,
  output logic                        power_lamp,
  output logic                        activity_lamp,
  output logic                        status_lamp,
  output logic [NUM_PORTS-1:0]        port_speed_yellow,
  output logic [NUM_PORTS-1:0]        port_speed_green,
  output logic [NUM_PORTS-1:0]        port_connection_traffic_lamp,
  output logic                        reboot_keep_cfg,
  output logic                        reboot_factory,
  output logic                        dflt_hostname_from_serial,
  output fpi_pkg::fpi_addr_mode_t     dflt_addr_mode,
  output logic [7:0]                  dflt_comment_len,
  output logic                        dflt_admin_pw_needed
);
  import fpi_pkg::*;

  localparam int TW = $clog2(TICK_CYC + 1);
  localparam int HW = $clog2(HOLD_MS + 1);
  localparam int FW = $clog2(FLICKER_HALF_MS + 1);
  localparam int AW = $clog2(TRAFFIC_HOLD_MS + 1);

  typedef enum logic [1:0] {BTN_IDLE, BTN_SHORT, BTN_LONG} fpi_btn_state_t;

  fpi_pace_if pace ();

  logic [TW-1:0]  tick_cnt;
  logic [TW-1:0]  next_tick_cnt;
  logic           tick;
  logic           next_tick;
  logic [FW-1:0]  flick_cnt;
  logic [FW-1:0]  next_flick_cnt;
  logic           flicker;
  logic           next_flicker;

  logic           btn_down;
  logic           fault_lamp;

  fpi_btn_state_t btn_state;
  fpi_btn_state_t next_btn_state;
  logic [HW-1:0]  hold_cnt;
  logic [HW-1:0]  next_hold_cnt;
  logic           next_reboot_keep;
  logic           next_reboot_factory;

  logic           next_power_lamp;
  logic           next_activity_lamp;
  logic           next_status_lamp;

  logic           next_dflt_host;
  fpi_addr_mode_t next_dflt_addr;
  logic [7:0]     next_dflt_comment;
  logic           next_dflt_pw;

  assign pace.tick_ms = tick;
  assign pace.flicker = flicker;

  // Millisecond divider and the traffic flicker square wave it paces.
  always_comb
  begin
    next_tick      = 1'b0;
    next_tick_cnt  = tick_cnt + 1'b1;
    next_flick_cnt = flick_cnt;
    next_flicker   = flicker;
    if (tick_cnt >= TW'(TICK_CYC - 1))
    begin
      next_tick_cnt = '0;
      next_tick     = 1'b1;
    end
    if (tick)
    begin
      if (flick_cnt >= FW'(FLICKER_HALF_MS - 1))
      begin
        next_flick_cnt = '0;
        next_flicker   = ~flicker;
      end
      else
      begin
        next_flick_cnt = flick_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      tick_cnt  <= '0;
      tick      <= 1'b0;
      flick_cnt <= '0;
      flicker   <= 1'b0;
    end
    else
    begin
      tick_cnt  <= next_tick_cnt;
      tick      <= next_tick;
      flick_cnt <= next_flick_cnt;
      flicker   <= next_flicker;
    end
  end

  // Contact bounce is filtered before anything times the press.
  fpi_debounce #(
    .DEB_MS (DEB_MS)
  ) u_debounce (
    .clk    (clk),
    .rst    (rst),
    .pace   (pace.snk),
    .raw    (reset_button),
    .stable (btn_down)
  );

  fpi_fault_blink u_fault_blink (
    .clk    (clk),
    .rst    (rst),
    .pace   (pace.snk),
    .enable (fw_image_corrupt),
    .lamp   (fault_lamp)
  );

  // Press timing; the hold counter saturates so a very long press stays long.
  always_comb
  begin
    next_btn_state      = btn_state;
    next_hold_cnt       = hold_cnt;
    next_reboot_keep    = 1'b0;
    next_reboot_factory = 1'b0;
    case (btn_state)
      BTN_IDLE:
      begin
        next_hold_cnt = '0;
        if (btn_down)
        begin
          next_btn_state = BTN_SHORT;   // [RULE_15]
        end
      end
      BTN_SHORT:
      begin
        if (!btn_down)
        begin
          next_btn_state   = BTN_IDLE;
          next_reboot_keep = 1'b1;   // [RULE_11]
        end
        else if (tick)
        begin
          if (hold_cnt >= HW'(HOLD_MS - 1))
          begin
            next_btn_state = BTN_LONG;   // [RULE_12]
          end
          else
          begin
            next_hold_cnt = hold_cnt + 1'b1;
          end
        end
      end
      BTN_LONG:
      begin
        if (!btn_down)
        begin
          next_btn_state      = BTN_IDLE;
          next_reboot_factory = 1'b1;   // [RULE_13]
        end
      end
      default:
      begin
        next_btn_state = BTN_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      btn_state       <= BTN_IDLE;
      hold_cnt        <= '0;
      reboot_keep_cfg <= 1'b0;
      reboot_factory  <= 1'b0;
    end
    else
    begin
      btn_state       <= next_btn_state;
      hold_cnt        <= next_hold_cnt;
      reboot_keep_cfg <= next_reboot_keep;
      reboot_factory  <= next_reboot_factory;
    end
  end

  // Chassis lamps. A long hold outranks every other status lamp source, since the operator
  // needs to see the moment the press turns into a factory restore.
  always_comb
  begin
    next_power_lamp    = power_good;     // [RULE_01]
    next_activity_lamp = task_running;   // [RULE_02]
    if (btn_state == BTN_LONG)
    begin
      next_status_lamp = 1'b1;   // [RULE_12]
    end
    else if (fw_booting || fw_updating || fw_restoring)
    begin
      next_status_lamp = 1'b1;   // [RULE_04]
    end
    else if (fw_image_corrupt)
    begin
      next_status_lamp = fault_lamp;   // [RULE_05]
    end
    else
    begin
      next_status_lamp = 1'b0;   // [RULE_03]
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      power_lamp    <= 1'b0;
      activity_lamp <= 1'b0;
      status_lamp   <= 1'b0;
    end
    else
    begin
      power_lamp    <= next_power_lamp;
      activity_lamp <= next_activity_lamp;
      status_lamp   <= next_status_lamp;
    end
  end

  // Factory values are presented with the factory reboot pulse and then held.
  always_comb
  begin
    next_dflt_host    = dflt_hostname_from_serial;
    next_dflt_addr    = dflt_addr_mode;
    next_dflt_comment = dflt_comment_len;
    next_dflt_pw      = dflt_admin_pw_needed;
    if (next_reboot_factory)
    begin
      next_dflt_host    = DFLT_HOST_SERIAL;      // [RULE_14]
      next_dflt_addr    = ADDR_DHCP_LINKLOCAL;   // [RULE_14]
      next_dflt_comment = DFLT_COMMENT_LEN;      // [RULE_14]
      next_dflt_pw      = DFLT_PW_NEEDED;        // [RULE_14]
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      dflt_hostname_from_serial <= 1'b0;
      dflt_addr_mode            <= ADDR_STATIC;
      dflt_comment_len          <= 8'h00;
      dflt_admin_pw_needed      <= 1'b0;
    end
    else
    begin
      dflt_hostname_from_serial <= next_dflt_host;
      dflt_addr_mode            <= next_dflt_addr;
      dflt_comment_len          <= next_dflt_comment;
      dflt_admin_pw_needed      <= next_dflt_pw;
    end
  end

  // Per-port lamps. A frame restarts a short window in which the traffic
  // lamp flickers; bursts shorter than the window look like one blink.
  for (genvar p = 0; p < NUM_PORTS; p++)
  begin : g_port   // [RULE_10]
    logic [AW-1:0] act_cnt;
    logic [AW-1:0] next_act_cnt;
    logic          next_yellow;
    logic          next_green;
    logic          next_traffic;

    always_comb
    begin
      next_act_cnt = act_cnt;
      if (!port_link_up[p])
      begin
        next_act_cnt = '0;
      end
      else if (port_frame_seen[p])
      begin
        next_act_cnt = AW'(TRAFFIC_HOLD_MS);
      end
      else if (tick && (act_cnt != '0))
      begin
        next_act_cnt = act_cnt - 1'b1;
      end
      next_yellow  = port_link_up[p] && (port_speed[p] == SPEED_1000);   // [RULE_06] [RULE_08]
      next_green   = port_link_up[p] && (port_speed[p] == SPEED_100);    // [RULE_07] [RULE_08]
      next_traffic = port_link_up[p] && ((act_cnt == '0) || flicker);    // [RULE_09]
    end

    always_ff @(posedge clk)
    begin
      if (rst)
      begin
        act_cnt                         <= '0;
        port_speed_yellow[p]            <= 1'b0;
        port_speed_green[p]             <= 1'b0;
        port_connection_traffic_lamp[p] <= 1'b0;
      end
      else
      begin
        act_cnt                         <= next_act_cnt;
        port_speed_yellow[p]            <= next_yellow;
        port_speed_green[p]             <= next_green;
        port_connection_traffic_lamp[p] <= next_traffic;
      end
    end
  end

endmodule : fpi_front_panel

// >>> fpi_checker.sv
`timescale 1ns/1ps
// Port-level watcher for lamp timing, reboot pulses and restored defaults.
module fpi_checker
  import fpi_pkg::*;
#(
  parameter int unsigned TICK_CYC  = 4,
  parameter int unsigned DEB_MS    = 2,
  parameter int unsigned NUM_PORTS = 2
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 power_good,
  input  wire logic                 task_running,
  input  wire logic                 fw_booting,
  input  wire logic                 fw_updating,
  input  wire logic                 fw_restoring,
  input  wire logic                 fw_image_corrupt,
  input  wire logic                 reset_button,
  input  wire logic [NUM_PORTS-1:0] port_link_up,
  input  fpi_pkg::fpi_speed_t       port_speed [NUM_PORTS],
  input  wire logic                 power_lamp,
  input  wire logic                 activity_lamp,
  input  wire logic                 status_lamp,
  input  wire logic [NUM_PORTS-1:0] port_speed_yellow,
  input  wire logic [NUM_PORTS-1:0] port_speed_green,
  input  wire logic [NUM_PORTS-1:0] port_connection_traffic_lamp,
  input  wire logic                 reboot_keep_cfg,
  input  wire logic                 reboot_factory,
  input  wire logic                 dflt_hostname_from_serial,
  input  fpi_pkg::fpi_addr_mode_t   dflt_addr_mode,
  input  wire logic [7:0]           dflt_comment_len,
  input  wire logic                 dflt_admin_pw_needed
);
  localparam int QUIET_MIN = (DEB_MS + 2) * TICK_CYC + 8;
  logic                 rst_q;
  logic                 busy_fw;
  logic [NUM_PORTS-1:0] yel_exp;
  logic [NUM_PORTS-1:0] grn_exp;
  logic [15:0]          quiet;
  logic [15:0]          next_quiet;

  // Expected colours; the quiet count saturates so it never wraps to zero.
  always_comb
  begin
    for (int i = 0; i < NUM_PORTS; i++)
    begin
      yel_exp[i] = port_link_up[i] && (port_speed[i] == SPEED_1000);
      grn_exp[i] = port_link_up[i] && (port_speed[i] == SPEED_100);
    end
    busy_fw = fw_booting | fw_updating | fw_restoring;
    next_quiet = (rst | busy_fw | fw_image_corrupt | reset_button) ? 16'h0000
               : (quiet == 16'hffff) ? quiet : quiet + 16'h0001;
  end

  // Registers only; the delayed reset masks the first edge after release.
  always_ff @(posedge clk)
  begin
    rst_q <= rst;
    quiet <= next_quiet;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || rst_q);

  AST_POWER: assert property (power_lamp == $past(power_good))
    else $error("power lamp does not follow power good");
  AST_ACTIVE: assert property (activity_lamp == $past(task_running))
    else $error("activity lamp does not follow task state");
  AST_QUIET: assert property (quiet > QUIET_MIN |-> !status_lamp)
    else $error("status lamp lit in normal operation");
  AST_BUSY: assert property ($past(busy_fw) |-> status_lamp)
    else $error("status lamp dark during boot or update");
  AST_YELLOW: assert property (port_speed_yellow == $past(yel_exp))
    else $error("yellow speed lamp wrong");
  AST_GREEN: assert property (port_speed_green == $past(grn_exp))
    else $error("green speed lamp wrong");
  AST_NOLINK: assert property ((port_connection_traffic_lamp & ~$past(port_link_up)) == '0)
    else $error("traffic lamp lit without link");
  AST_PULSE: assert property (reboot_factory |-> !reboot_keep_cfg ##1 !reboot_factory)
    else $error("factory reboot pulse malformed");
  AST_RELEASE: assert property (reboot_keep_cfg || reboot_factory |-> $past(!reset_button, 2))
    else $error("reboot while button still pressed");
  AST_LONGLIT: assert property (reboot_factory |-> $past(status_lamp))
    else $error("status lamp dark before factory reboot");
  AST_DFLT: assert property (reboot_factory |-> dflt_hostname_from_serial &&
    dflt_addr_mode == ADDR_DHCP_LINKLOCAL && dflt_comment_len == 8'h00 && !dflt_admin_pw_needed)
    else $error("defaults wrong at factory reboot");
  AST_DHOLD: assert property (!reboot_factory |-> $stable(dflt_addr_mode) &&
    $stable(dflt_hostname_from_serial) && $stable(dflt_admin_pw_needed))
    else $error("defaults changed without factory reboot");

  COV_KEEP: cover property (reboot_keep_cfg);
  COV_FACT: cover property (reboot_factory);
  COV_BLINK: cover property (fw_image_corrupt && $rose(status_lamp));
endmodule : fpi_checker

// >>> fpi_operator.sv
`timescale 1ns/1ps
// Operator at the reset button; a press may open with contact bounce.
module fpi_operator (
  input  wire logic clk,
  output logic      reset_button
);
  initial reset_button = 1'b0;

  // Bounce, then hold for the given cycles and let go cleanly.
  task automatic press(input int cyc, input int bounces);
    for (int i = 0; i < bounces; i++)
    begin
      @(posedge clk);
      #10 reset_button = ~reset_button;
    end
    @(posedge clk);
    #10 reset_button = 1'b1;
    repeat (cyc) @(posedge clk);
    #10 reset_button = 1'b0;
  endtask : press
endmodule : fpi_operator

// >>> front_panel_indicator_reset_tb.sv
`timescale 1ns/1ps
// Self-checking bench for the front panel lamps and the reset button.
module front_panel_indicator_reset_tb;
  import fpi_pkg::*;
  localparam int unsigned TCYC = 4;
  localparam int unsigned HOLD = 6;
  localparam int unsigned DEB  = 2;
  logic            clk, rst, power_good, task_running, reset_button;
  logic            fw_booting, fw_updating, fw_restoring, fw_image_corrupt;
  logic [1:0]      port_link_up, port_frame_seen, port_speed_yellow, port_speed_green;
  logic [1:0]      port_connection_traffic_lamp, ey, eg;
  fpi_speed_t      port_speed [2];
  logic            power_lamp, activity_lamp, status_lamp, reboot_keep_cfg, reboot_factory;
  logic            dflt_hostname_from_serial, dflt_admin_pw_needed, prev;
  fpi_addr_mode_t  dflt_addr_mode;
  logic [7:0]      dflt_comment_len;
  logic [31:0]     seed;
  int              failures, comparisons, n_keep, n_fact, lo, hi, w, rises;

  fpi_front_panel #(.TICK_CYC(TCYC), .HOLD_MS(HOLD), .DEB_MS(DEB), .NUM_PORTS(2)) i_dut (.*);
  fpi_operator i_op (.clk(clk), .reset_button(reset_button));

  // Free-running 10 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Counts reboot pulses as the operator would see the chassis restart.
  always @(posedge clk)
  begin
    n_keep += int'(reboot_keep_cfg);
    n_fact += int'(reboot_factory);
  end

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // Inputs change and outputs are read a fixed 10 ns after the edge.
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask : step

  task automatic close_out;
    if (failures == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out

  // Cuts a hang short well beyond the expected run length.
  initial
  begin
    repeat (60000) @(posedge clk);
    failures++;
    close_out();
  end

  // Main sequence: random lamps, traffic, fault pattern, button presses.
  initial
  begin
    {rst, power_good, task_running, fw_booting, fw_updating, fw_restoring} = 6'h20;
    fw_image_corrupt = 1'b0;
    port_link_up = 2'h0;
    port_frame_seen = 2'h0;
    port_speed = '{SPEED_10, SPEED_10};
    seed = 32'h98d9;
    step(4);
    rst = 1'b0;
    chk({power_lamp, status_lamp, port_speed_yellow, reboot_factory}, 8'h00, "reset");
    for (int i = 0; i < 300; i++)
    begin
      seed = xs(seed);
      {port_link_up, task_running, power_good} = seed[3:0];
      port_speed[0] = fpi_speed_t'(seed[5:4] % 2'h3);
      port_speed[1] = fpi_speed_t'(seed[7:6] % 2'h3);
      fw_booting = &seed[9:8];
      fw_updating = &seed[11:10];
      fw_restoring = &seed[13:12];
      for (int p = 0; p < 2; p++)
      begin
        ey[p] = port_link_up[p] && port_speed[p] == SPEED_1000;
        eg[p] = port_link_up[p] && port_speed[p] == SPEED_100;
      end
      step(1);
      chk(power_lamp, power_good, "power");
      chk(activity_lamp, task_running, "activity");
      chk(status_lamp, fw_booting | fw_updating | fw_restoring, "status");
      chk({port_speed_yellow, port_speed_green}, {ey, eg}, "speed");
      chk(port_connection_traffic_lamp, port_link_up, "link");
    end
    {fw_booting, fw_updating, fw_restoring} = 3'h0;
    port_link_up = 2'h3;
    step(2);
    port_frame_seen = 2'h1;
    step(1);
    port_frame_seen = 2'h0;
    lo = 0;
    hi = 0;
    for (int i = 0; i < 90 * TCYC; i++)
    begin
      step(1);
      lo += int'(!port_connection_traffic_lamp[0]);
      hi += int'(port_connection_traffic_lamp[1]);
    end
    chk(lo > 0, 1'b1, "no blink");
    chk(hi == 90 * TCYC, 1'b1, "idle port disturbed");
    step(60 * TCYC);
    chk(port_connection_traffic_lamp[0], 1'b1, "steady after traffic");
    fw_image_corrupt = 1'b1;
    w = 0;
    while (!status_lamp && w < 10)
    begin
      step(1);
      w++;
    end
    chk(status_lamp, 1'b1, "fault start");
    {w, hi, rises, prev} = '0;
    for (int i = 0; i < 2900 * TCYC; i++)
    begin
      step(1);
      if (i < 302 * TCYC)
        w += int'(status_lamp);
      if (i >= 1600 * TCYC)
        hi += int'(status_lamp);
      rises += int'(status_lamp && !prev);
      prev = status_lamp;
    end
    chk(8'(rises), 8'(FAULT_BLINKS), "blink count");
    chk(w >= 298 * TCYC && w <= 301 * TCYC, 1'b1, "on time");
    chk(8'(hi), 8'h00, "gap lit");
    w = 0;
    while (!status_lamp && w < 500 * TCYC)
    begin
      step(1);
      w++;
    end
    chk(status_lamp, 1'b1, "pattern repeat");
    fw_image_corrupt = 1'b0;
    step(4);
    chk(status_lamp, 1'b0, "fault stop");
    {n_keep, n_fact} = '0;
    i_op.press(TCYC - 2, 0);
    step(20 * TCYC);
    chk(8'(n_keep + n_fact), 8'h00, "glitch reboot");
    i_op.press((HOLD - 2) * TCYC, 6);
    step((DEB + 3) * TCYC);
    chk(8'(n_keep), 8'h01, "short reboot");
    chk(8'(n_fact), 8'h00, "short as factory");
    fork
      i_op.press((HOLD + DEB + 5) * TCYC, 4);
      begin
        step((HOLD + DEB + 4) * TCYC);
        chk(status_lamp, 1'b1, "long hold lamp");
      end
    join
    step((DEB + 3) * TCYC);
    chk(8'(n_fact), 8'h01, "factory reboot");
    chk(8'(n_keep), 8'h01, "extra plain reboot");
    chk({dflt_hostname_from_serial, dflt_addr_mode, dflt_admin_pw_needed},
        {1'b1, ADDR_DHCP_LINKLOCAL, 1'b0}, "defaults");
    chk(dflt_comment_len, 8'h00, "comment");
    close_out();
  end
endmodule : front_panel_indicator_reset_tb

bind fpi_front_panel fpi_checker #(.TICK_CYC(TICK_CYC), .DEB_MS(DEB_MS), .NUM_PORTS(NUM_PORTS))
  i_chk (.*);
